// ===== src/sdci_defines.svh
// Register offsets, field positions, reset values and counts of the command-issue block.
// Assumes inclusion by bare name from package and design files.
`ifndef SDCI_DEFINES_SVH
`define SDCI_DEFINES_SVH

// Register byte offsets
`define SDCI_OFS_STATUS      8'h00
`define SDCI_OFS_MASK        8'h04
`define SDCI_OFS_ARGUMENT    8'h08
`define SDCI_OFS_COMMAND     8'h0C
`define SDCI_OFS_TX_DATA     8'h10

// Command register field positions
`define SDCI_BIT_DMA_EVENT   16
`define SDCI_BIT_FLAG_CLEAR  15
`define SDCI_BIT_INIT_CLOCK  14
`define SDCI_BIT_DATA_PHASE  13
`define SDCI_BIT_STREAM      12
`define SDCI_BIT_WRITE_DIR   11
`define SDCI_BIT_PUSH_PULL   7
`define SDCI_CMD_WRITE_MASK  32'h0001_FFBF

// Status and mask bit positions
`define SDCI_ST_CMD_DONE     0
`define SDCI_ST_INIT_DONE    1
`define SDCI_ST_RX_READY     2
`define SDCI_ST_TX_READY     3
`define SDCI_ST_LINE_LEVEL   4
`define SDCI_ST_W1C_MASK     5'h0F

// Reset values
`define SDCI_RST_COMMAND     32'h0000_0000
`define SDCI_RST_ARGUMENT    32'h0000_0000
`define SDCI_RST_TX_DATA     32'h0000_0000
`define SDCI_RST_MASK        5'h00
`define SDCI_RST_STATUS      5'h00

// Counts in card clock cycles
`define SDCI_INIT_CYCLES     7'd80
`define SDCI_FRAME_BITS      7'd48
`define SDCI_RESP_SHORT      8'd48
`define SDCI_RESP_LONG       8'd136

`endif

// ===== src/sdci_pkg.sv
// Types shared by the command-issue block.
// Assumes sdci_defines.svh for the numeric constants.
package sdci_pkg;

  typedef enum logic [3:0] {
    SDCI_IDLE = 4'b0001,
    SDCI_INIT = 4'b0010,
    SDCI_SEND = 4'b0100,
    SDCI_DATA = 4'b1000
  } sdci_state_e;

  typedef struct packed {
    logic [14:0] rsv_high;
    logic        dma_event_enable;
    logic        ready_flag_clear;
    logic        init_clock_insert;
    logic        data_phase_flag;
    logic        stream_select;
    logic        write_direction;
    logic [1:0]  response_format;
    logic        busy_expected;
    logic        push_pull_select;
    logic        rsv_low;
    logic [5:0]  command_index;
  } sdci_cmd_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sdci_bus_s;

  typedef struct packed {
    logic cmd_out;
    logic cmd_oe_n;
  } sdci_pin_s;

  typedef struct packed {
    logic [1:0] format;
    logic [7:0] length;
    logic       crc_check;
    logic       busy;
  } sdci_resp_s;

  typedef struct packed {
    logic active;
    logic write;
    logic stream;
  } sdci_data_s;

endpackage : sdci_pkg

// ===== src/sdci_crc7.sv
// CRC7 over the 40 leading bits of a command frame.
// Assumes the caller holds the header stable while it uses the result.
`timescale 1ns/100ps
module sdci_crc7 (
  input  wire logic [39:0] header_in,
  output logic      [6:0]  crc_out
);
  always_comb begin
    logic [6:0] c;
    logic       fb;
    c  = 7'h00;
    fb = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      fb = header_in[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    crc_out = c;
  end
endmodule : sdci_crc7

// ===== src/sdci_sync.sv
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes a synchronous active-high reset and a clock enable.
`timescale 1ns/100ps
module sdci_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sdci_sync_s;

  sdci_sync_s s_q;
  sdci_sync_s s_d;

  always_comb begin
    s_d        = s_q;
    s_d.stage1 = async_in;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stage2;
endmodule : sdci_sync

// ===== src/sdci_top.sv
// Command-issue front end: register port, command frame serialiser, ready flags.
// Assumes a 50 MHz core clock, a card clock input sampled here, and a data
// path on the same clock that reports word moves as one-cycle pulses.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "sdci_defines.svh"

// Summary of operation
// - Writing the command register starts sending the command with the current argument.
// - The command register keeps its written value with bits 31:17 and bit 6 cleared; reads return that value.
// - Bit 16 enables DMA requests for the data transfer; clear means none.
// - A command write with bit 15 set clears both ready flags.
// - Bit 14 inserts 80 card clock cycles before the frame.
// - Bit 13 set runs a data phase after the command; clear runs none.
// - Frame is 48 bits: start, transmit, index, argument, CRC7, end.
// - Response format: none, 48 with CRC, 136 with CRC, 48 without CRC.
// - In a data phase bit 11 picks write or read, stream bit picks unbounded.
// - Bit 7 selects push-pull drive; clear selects open-drain drive.
module sdci_top (
  input  wire logic                core_clk_in,
  input  wire logic                srst_in,
  input  wire logic                ce_in,
  input  wire sdci_pkg::sdci_bus_s bus_in,
  output logic      [31:0]         rdata_out,
  input  wire logic                card_clk_in,
  input  wire logic                cmd_in,
  output sdci_pkg::sdci_pin_s      cmd_pin_out,
  input  wire logic                tx_word_take_in,
  input  wire logic                rx_word_valid_in,
  input  wire logic                data_done_in,
  output logic      [31:0]         tx_payload_out,
  output sdci_pkg::sdci_data_s     data_ctl_out,
  output sdci_pkg::sdci_resp_s     resp_ctl_out,
  output logic                     dma_tx_req_out,
  output logic                     dma_rx_req_out,
  output logic                     busy_out,
  output logic                     irq_out
);
  import sdci_pkg::*;

  typedef struct packed {
    sdci_state_e st;
    sdci_cmd_s   cmd;
    logic [31:0] arg;
    logic [31:0] txw;
    logic [4:0]  mask;
    logic [3:0]  sticky;
    logic [47:0] shreg;
    logic [6:0]  cnt;
    logic        cmd_o;
    logic        oe_n;
    logic [31:0] rdata;
    logic        clk_prev;
    logic        dma_tx;
    logic        dma_rx;
  } sdci_top_s;

  sdci_top_s  s_q;
  sdci_top_s  s_d;
  logic [1:0] sync_lv;
  logic       clk_lv;
  logic       line_lv;
  logic       clk_rise;
  logic       clk_fall;
  logic [39:0] crc_hdr;
  logic [6:0]  crc_val;
  sdci_cmd_s   wcmd;
  logic        cmd_wr;
  logic [4:0]  status;

  // Card clock and command line levels into the core domain
  sdci_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .async_in    ({card_clk_in, cmd_in}),
    .sync_out    (sync_lv)
  );

  assign clk_lv   = sync_lv[1];
  assign line_lv  = sync_lv[0];
  assign clk_rise = clk_lv & ~s_q.clk_prev;
  assign clk_fall = ~clk_lv & s_q.clk_prev;

  // Frame header from the written index and the held argument
  assign wcmd    = sdci_cmd_s'(bus_in.wdata & `SDCI_CMD_WRITE_MASK);
  assign cmd_wr  = bus_in.wr && (bus_in.addr == `SDCI_OFS_COMMAND);
  assign crc_hdr = {2'b01, wcmd.command_index, s_q.arg};

  sdci_crc7 u_crc (
    .header_in (crc_hdr),
    .crc_out   (crc_val)
  );

  assign status = {line_lv, s_q.sticky};

  always_comb begin
    logic tx_set;
    logic rx_set;
    logic bit_now;
    tx_set  = 1'b0;
    rx_set  = 1'b0;
    bit_now = 1'b0;
    s_d          = s_q;
    s_d.clk_prev = clk_lv;
    s_d.dma_tx   = 1'b0;
    s_d.dma_rx   = 1'b0;

    // Register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        `SDCI_OFS_STATUS: begin
          s_d.sticky = s_q.sticky & ~bus_in.wdata[3:0];
        end
        `SDCI_OFS_MASK: begin
          s_d.mask = bus_in.wdata[4:0];
        end
        `SDCI_OFS_ARGUMENT: begin
          s_d.arg = bus_in.wdata;
        end
        `SDCI_OFS_TX_DATA: begin
          s_d.txw = bus_in.wdata;
          s_d.sticky[`SDCI_ST_TX_READY] = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Command write: store, then launch at once
    if (cmd_wr) begin
      s_d.cmd   = wcmd;
      s_d.shreg = {2'b01, wcmd.command_index, s_q.arg, crc_val, 1'b1};
      s_d.cnt   = 7'd0;
      s_d.cmd_o = 1'b1;
      s_d.oe_n  = 1'b1;
      if (wcmd.ready_flag_clear) begin
        s_d.sticky[`SDCI_ST_RX_READY] = 1'b0;
        s_d.sticky[`SDCI_ST_TX_READY] = 1'b0;
      end
      s_d.st = wcmd.init_clock_insert ? SDCI_INIT : SDCI_SEND;
    end else begin
      case (s_q.st)
        SDCI_IDLE: begin
          s_d.oe_n = 1'b1;
        end
        SDCI_INIT: begin
          if (clk_rise && s_q.cnt != `SDCI_INIT_CYCLES) begin
            s_d.cnt = s_q.cnt + 7'd1;
          end
          if (clk_fall && s_q.cnt == `SDCI_INIT_CYCLES) begin
            s_d.cnt = 7'd0;
            s_d.st  = SDCI_SEND;
            s_d.sticky[`SDCI_ST_INIT_DONE] = 1'b1;
          end
        end
        SDCI_SEND: begin
          if (clk_fall) begin
            if (s_q.cnt != `SDCI_FRAME_BITS) begin
              bit_now   = s_q.shreg[47];
              s_d.shreg = {s_q.shreg[46:0], 1'b0};
              s_d.cnt   = s_q.cnt + 7'd1;
              if (s_q.cmd.push_pull_select) begin
                s_d.cmd_o = bit_now;
                s_d.oe_n  = 1'b0;
              end else begin
                s_d.cmd_o = 1'b0;
                s_d.oe_n  = bit_now;
              end
            end else begin
              s_d.cmd_o = 1'b1;
              s_d.oe_n  = 1'b1;
              s_d.sticky[`SDCI_ST_CMD_DONE] = 1'b1;
              s_d.st = s_q.cmd.data_phase_flag ? SDCI_DATA : SDCI_IDLE;
            end
          end
        end
        SDCI_DATA: begin
          if (data_done_in) begin
            s_d.st = SDCI_IDLE;
          end
        end
        default: begin
          s_d.st   = SDCI_IDLE;
          s_d.oe_n = 1'b1;
        end
      endcase
    end

    // Ready flags from the data path; a set beats any clear
    tx_set = tx_word_take_in && s_q.st == SDCI_DATA && s_q.cmd.write_direction;
    rx_set = rx_word_valid_in && s_q.st == SDCI_DATA && !s_q.cmd.write_direction;
    if (tx_set) begin
      s_d.sticky[`SDCI_ST_TX_READY] = 1'b1;
      s_d.dma_tx = s_q.cmd.dma_event_enable;
    end
    if (rx_set) begin
      s_d.sticky[`SDCI_ST_RX_READY] = 1'b1;
      s_d.dma_rx = s_q.cmd.dma_event_enable;
    end

    // Read data, valid in the following cycle only
    s_d.rdata = 32'h0000_0000;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `SDCI_OFS_STATUS:   s_d.rdata = {27'h0, status};
        `SDCI_OFS_MASK:     s_d.rdata = {27'h0, s_q.mask};
        `SDCI_OFS_ARGUMENT: s_d.rdata = s_q.arg;
        `SDCI_OFS_COMMAND:  s_d.rdata = s_q.cmd;
        `SDCI_OFS_TX_DATA:  s_d.rdata = s_q.txw;
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q.st       <= SDCI_IDLE;
      s_q.cmd      <= `SDCI_RST_COMMAND;
      s_q.arg      <= `SDCI_RST_ARGUMENT;
      s_q.txw      <= `SDCI_RST_TX_DATA;
      s_q.mask     <= `SDCI_RST_MASK;
      s_q.sticky   <= 4'h0;
      s_q.shreg    <= 48'h0000_0000_0000;
      s_q.cnt      <= 7'd0;
      s_q.cmd_o    <= 1'b1;
      s_q.oe_n     <= 1'b1;
      s_q.rdata    <= 32'h0000_0000;
      s_q.clk_prev <= 1'b0;
      s_q.dma_tx   <= 1'b0;
      s_q.dma_rx   <= 1'b0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign rdata_out            = s_q.rdata;
  assign cmd_pin_out.cmd_out  = s_q.cmd_o;
  assign cmd_pin_out.cmd_oe_n = s_q.oe_n;
  assign tx_payload_out       = s_q.txw;
  assign data_ctl_out.active  = (s_q.st == SDCI_DATA);
  assign data_ctl_out.write   = s_q.cmd.write_direction;
  assign data_ctl_out.stream  = s_q.cmd.stream_select;
  assign dma_tx_req_out       = s_q.dma_tx;
  assign dma_rx_req_out       = s_q.dma_rx;
  assign busy_out             = (s_q.st != SDCI_IDLE);
  assign irq_out              = |(status & s_q.mask);

  // Expected reply length and CRC check
  always_comb begin
    resp_ctl_out.format = s_q.cmd.response_format;
    resp_ctl_out.busy   = s_q.cmd.busy_expected;
    case (s_q.cmd.response_format)
      2'd1: begin
        resp_ctl_out.length    = `SDCI_RESP_SHORT;
        resp_ctl_out.crc_check = 1'b1;
      end
      2'd2: begin
        resp_ctl_out.length    = `SDCI_RESP_LONG;
        resp_ctl_out.crc_check = 1'b1;
      end
      2'd3: begin
        resp_ctl_out.length    = `SDCI_RESP_SHORT;
        resp_ctl_out.crc_check = 1'b0;
      end
      default: begin
        resp_ctl_out.length    = 8'd0;
        resp_ctl_out.crc_check = 1'b0;
      end
    endcase
  end
endmodule : sdci_top

// ===== verification/sdci_card_model.sv
// Card-side model: card clock, pulled-up command line, frame capture.
// Assumes the bench raises run_in for each command it sends.
`timescale 1ns/100ps
module sdci_card_model (
  input  wire logic                run_in,
  input  wire sdci_pkg::sdci_pin_s pin_in,
  output logic                     card_clk_out,
  output logic                     line_out,
  output logic      [47:0]         frame_out,
  output logic      [7:0]          rises_out,
  output logic      [7:0]          start_rise_out,
  output logic                     done_out
);
  import sdci_pkg::*;
  logic [5:0] cnt;
  // Pull-up wins when the block releases the line
  assign line_out = pin_in.cmd_oe_n ? 1'b1 : pin_in.cmd_out;
  // Clock only while a command is in flight, off the core grid
  initial begin
    card_clk_out = 1'b0;
    {cnt, done_out, rises_out, frame_out, start_rise_out} = '0;
    #7;
    forever begin
      #80;
      if (run_in || card_clk_out) card_clk_out = ~card_clk_out;
    end
  end
  always @(posedge run_in) begin
    {cnt, done_out, rises_out} = '0;
  end
  always @(posedge card_clk_out) rises_out <= rises_out + 8'h01;
  // Shift in the frame from its start bit
  always @(negedge card_clk_out) begin
    if (!done_out && (cnt != 6'h00 || !line_out)) begin
      frame_out <= {frame_out[46:0], line_out};
      if (cnt == 6'h00) start_rise_out <= rises_out;
      done_out <= (cnt == 6'h2F);
      cnt <= (cnt == 6'h2F) ? 6'h00 : cnt + 6'h01;
    end
  end
endmodule : sdci_card_model

// ===== verification/sdci_top_assertions.sv
// Port-level checks of the command-issue block.
// Assumes one clock domain; bound into sdci_top.
`timescale 1ns/100ps
module sdci_top_assertions (
  input wire logic                 core_clk_in,
  input wire logic                 srst_in,
  input wire logic                 ce_in,
  input wire sdci_pkg::sdci_bus_s  bus_in,
  input wire logic [31:0]          rdata_out,
  input wire sdci_pkg::sdci_pin_s  cmd_pin_out,
  input wire logic                 tx_word_take_in,
  input wire logic                 data_done_in,
  input wire sdci_pkg::sdci_data_s data_ctl_out,
  input wire sdci_pkg::sdci_resp_s resp_ctl_out,
  input wire logic                 dma_tx_req_out,
  input wire logic                 dma_rx_req_out,
  input wire logic                 busy_out
);
  import sdci_pkg::*;
  logic [31:0] cmd_q;
  logic [4:0]  age_q;
  logic [1:0]  f;
  assign f = cmd_q[10:9];
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cmd_q <= 32'h0;
      age_q <= 5'h00;
    end else if (ce_in && bus_in.wr && bus_in.addr == 8'h0C) begin
      cmd_q <= bus_in.wdata;
      age_q <= 5'h00;
    end else if (ce_in && age_q != 5'h1F) begin
      age_q <= age_q + 5'h01;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in || !ce_in);
  read_idle_zero_a: assert property (!bus_in.rd |=> rdata_out == 32'h0)
    else $error("read data not zero");
  cmd_readback_a: assert property (
    bus_in.rd && bus_in.addr == 8'h0C |=> rdata_out == (cmd_q & 32'h0001_FFBF))
    else $error("command readback wrong");
  launch_busy_a: assert property (bus_in.wr && bus_in.addr == 8'h0C |=> busy_out)
    else $error("command write did not launch");
  idle_release_a: assert property (
    !busy_out && $past(!busy_out) |-> cmd_pin_out.cmd_out && cmd_pin_out.cmd_oe_n)
    else $error("line driven while idle");
  push_pull_a: assert property (
    cmd_q[7] && age_q == 5'h1F |-> !(!cmd_pin_out.cmd_out && cmd_pin_out.cmd_oe_n))
    else $error("push-pull pin state wrong");
  open_drain_a: assert property (
    !cmd_q[7] && age_q == 5'h1F |-> !(cmd_pin_out.cmd_out && !cmd_pin_out.cmd_oe_n))
    else $error("open-drain drove high");
  dma_gate_a: assert property ((dma_tx_req_out || dma_rx_req_out) |-> cmd_q[16])
    else $error("dma request while disabled");
  resp_decode_a: assert property (age_q > 5'h02 |-> resp_ctl_out ==
    {f, f == 2'h0 ? 8'h00 : f == 2'h2 ? 8'h88 : 8'h30, f == 2'h1 || f == 2'h2, cmd_q[8]})
    else $error("response decode wrong");
  data_dir_a: assert property (data_ctl_out.active && age_q > 5'h02 |->
    cmd_q[13] && data_ctl_out.write == cmd_q[11] && data_ctl_out.stream == cmd_q[12])
    else $error("data phase control wrong");
  data_end_a: assert property (
    data_ctl_out.active && data_done_in |-> ##[1:2] !data_ctl_out.active)
    else $error("data phase did not end");
  dma_tx_pulse_a: assert property (
    tx_word_take_in && data_ctl_out.active && data_ctl_out.write && cmd_q[16] |=> dma_tx_req_out)
    else $error("dma request missing");
endmodule : sdci_top_assertions

bind sdci_top sdci_top_assertions u_chk (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .cmd_pin_out(cmd_pin_out), .tx_word_take_in(tx_word_take_in), .ce_in(ce_in),
  .data_done_in(data_done_in), .data_ctl_out(data_ctl_out), .resp_ctl_out(resp_ctl_out),
  .dma_tx_req_out(dma_tx_req_out), .dma_rx_req_out(dma_rx_req_out), .busy_out(busy_out));

// ===== verification/sdci_top_test.sv
// Self-checking bench for the command-issue block.
// Assumes the card model makes the card clock and pulls the line up.
`timescale 1ns/100ps
module sdci_top_test;
  import sdci_pkg::*;
  logic        clk = 0, srst = 1, run = 0, take = 0, rxv = 0, ddone = 0, ce = 1;
  sdci_bus_s   bus = '0;
  sdci_pin_s   pin;
  sdci_data_s  dctl;
  sdci_resp_s  resp;
  logic [31:0] rdata, payload;
  logic        cclk, line, mdone, dtx, drx, busy, irq;
  logic [47:0] frame;
  logic [7:0]  rises, srise;
  int          failures = 0, n_compared = 0, cycles = 0;
  always #10 clk = ~clk;
  sdci_top uut (.core_clk_in(clk), .srst_in(srst), .ce_in(ce), .bus_in(bus),
    .rdata_out(rdata), .card_clk_in(cclk), .cmd_in(line), .cmd_pin_out(pin),
    .tx_word_take_in(take), .rx_word_valid_in(rxv), .data_done_in(ddone),
    .tx_payload_out(payload), .data_ctl_out(dctl), .resp_ctl_out(resp),
    .dma_tx_req_out(dtx), .dma_rx_req_out(drx), .busy_out(busy), .irq_out(irq));
  sdci_card_model card (.run_in(run), .pin_in(pin), .card_clk_out(cclk), .line_out(line),
    .frame_out(frame), .rises_out(rises), .start_rise_out(srise), .done_out(mdone));
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  function automatic logic [6:0] crc7(input logic [39:0] h);
    logic [6:0] c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((h[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction : crc7
  task automatic send(input logic [31:0] cmd, input logic [31:0] arg);
    run <= 1'b0;
    wr(8'h08, arg);
    run <= 1'b1;
    wr(8'h0C, cmd);
    for (int i = 0; i < 3000 && mdone !== 1'b1; i++) @(posedge clk);
    chk(mdone, 1'b1);
    repeat (20) @(posedge clk);
    run <= 1'b0;
    #1 chk(frame, {2'b01, cmd[5:0], arg, crc7({2'b01, cmd[5:0], arg}), 1'b1});
  endtask : send
  task automatic pulse(input logic rx, input logic exp);
    logic [2:0] n = 3'h0;
    @(posedge clk) {rxv, take} <= {rx, !rx};
    @(posedge clk) {rxv, take} <= 2'b00;
    repeat (5) begin
      #1 n = n + {2'b00, rx ? drx : dtx};
      @(posedge clk);
    end
    chk(n, {2'b00, exp});
  endtask : pulse
  task automatic t_regs();
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h00, 32'h10);
    wr(8'h10, 32'hC0DE_5A17);
    rd_chk(8'h10, 32'hC0DE_5A17);
    chk(payload, 32'hC0DE_5A17);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0);
  endtask : t_regs
  task automatic t_frames();
    send(32'h0000_4005, 32'hA5C3_0F96);
    chk(srise >= 8'h50 && srise <= 8'h52, 1'b1);
    send(32'h0000_0091, 32'h1234_5678);
    chk(srise < 8'h03, 1'b1);
    rd_chk(8'h0C, 32'h0000_0091);
    rd_chk(8'h00, 32'h13);
    wr(8'h04, 32'h01);
    chk(irq, 1'b1);
    wr(8'h00, 32'h01);
    chk(irq, 1'b0);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd_chk(8'h0C, 32'h0001_FFBF);
  endtask : t_frames
  task automatic t_data();
    send(32'h0001_2898, 32'h0000_0200);
    chk(dctl, 3'b110);
    pulse(1'b0, 1'b1);
    rd_chk(8'h00, 32'h1B);
    @(posedge clk) ddone <= 1'b1;
    @(posedge clk) ddone <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({dctl.active, busy}, 2'b00);
    send(32'h0000_1098, 32'h0);
    chk(dctl.active, 1'b0);
    send(32'h0001_3098, 32'h0);
    chk(dctl, 3'b101);
    pulse(1'b1, 1'b1);
    rd_chk(8'h00, 32'h1F);
    wr(8'h0C, 32'h0000_8080);
    rd_chk(8'h00, 32'h13);
  endtask : t_data
  task automatic t_reset();
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk({busy, pin, irq}, 4'b0110);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h0C, 32'h0);
    @(posedge clk) ce <= 1'b0;
    wr(8'h04, 32'h1F);
    @(posedge clk) ce <= 1'b1;
    rd_chk(8'h04, 32'h0);
  endtask : t_reset
  task automatic t_resp();
    for (int f = 0; f < 4; f++) begin
      wr(8'h0C, {21'h0, f[1:0], f == 1, 8'h80});
      chk(resp, {f[1:0], f == 0 ? 8'h00 : f == 2 ? 8'h88 : 8'h30, f == 1 || f == 2, f == 1});
    end
  endtask : t_resp
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_frames();
    t_data();
    t_reset();
    t_resp();
    finish_test();
  end
endmodule : sdci_top_test
